//--- hw/primary_word_control_decode.sv
// primary serial word control decode with sampling phase adjust
//
// Contract
// (RL1) each frame takes 14-bit word, sends 16-bit result
// (RL2) ctrl 00, low pin: sample later
// (RL3) ctrl 00, high pin: sample earlier
// (RL4) ctrl 00, both pins: secondary frame at half
// (RL5) pins low, ctrl 01: sample later
// (RL6) pins low, ctrl 10: sample earlier
// (RL7) pins low, ctrl 11: secondary frame at half
// (RL8) other combinations: plain data transfer only
// (RL9) output on rising, input on falling shift edge
// (RL10) adjust lasts one period; step is signed
`default_nettype none
module primary_word_control_decode (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial link from host
    input wire logic shift_clk,
    input wire logic frame_sync_n,
    input wire logic data_in,
    input wire logic function_pin_low,
    input wire logic function_pin_high,
    // serial link to host
    output logic data_out,
    output logic second_frame_sync_n,
    // sampling instant toward the converter
    output logic sample_strobe
);
    // decode of the four control inputs
    function automatic word_ctrl_pkg::action_e decode(input logic [1:0] cb, input logic [1:0] fp);
        word_ctrl_pkg::action_e a;
        a = word_ctrl_pkg::ACT_NONE;
        // (RL8) unlisted codes ignored
        case ({cb, fp})
            4'b00_01: a = word_ctrl_pkg::ACT_LATER;
            4'b00_10: a = word_ctrl_pkg::ACT_EARLIER;
            4'b00_11: a = word_ctrl_pkg::ACT_SECOND;
            4'b01_00: a = word_ctrl_pkg::ACT_LATER;
            4'b10_00: a = word_ctrl_pkg::ACT_EARLIER;
            4'b11_00: a = word_ctrl_pkg::ACT_SECOND;
            default: a = word_ctrl_pkg::ACT_NONE;
        endcase
        return a;
    endfunction : decode

    // two-flop synchronisers; stage one feeds only stage two
    logic [4:0] s1_r, s2_r, s3_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle pin levels, so no false shift edge follows reset
            s1_r <= 5'h02;
            s2_r <= 5'h02;
            s3_r <= 5'h02;
        end else begin
            s1_r <= {function_pin_high, function_pin_low, data_in, frame_sync_n, shift_clk};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    wire logic sck_rise = s2_r[0] & ~s3_r[0];
    wire logic sck_fall = ~s2_r[0] & s3_r[0];
    wire logic fs_low = ~s2_r[1];
    wire logic din_s = s2_r[2];
    wire logic [1:0] pins_s = s2_r[4:3];

    // registers
    logic [word_ctrl_pkg::PER_W-1:0] period_r, period_nxt;
    logic [word_ctrl_pkg::STEP_W-1:0] step_r, step_nxt;
    logic [word_ctrl_pkg::WORD_W-1:0] result_r, result_nxt;
    logic [word_ctrl_pkg::WORD_W-1:0] rx_word_r, rx_word_nxt;
    logic [word_ctrl_pkg::WORD_W-1:0] shin_r, shin_nxt;
    logic [word_ctrl_pkg::WORD_W-1:0] shout_r, shout_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic active_r, active_nxt;
    logic armed_r, armed_nxt;
    logic [1:0] last_act_r, last_act_nxt;
    logic [word_ctrl_pkg::PER_W-1:0] cnt_r, cnt_nxt;
    logic [word_ctrl_pkg::PER_W-1:0] limit_r, limit_nxt;
    logic [word_ctrl_pkg::PER_W-1:0] half_cnt_r, half_cnt_nxt;
    logic half_run_r, half_run_nxt;
    logic strobe_r, strobe_nxt;
    logic fs2_r, fs2_nxt;
    logic dout_r, dout_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    wire logic apb_acc = psel & penable & ~pready_r;
    wire logic apb_wr = apb_acc & pwrite;
    // sign extended phase step
    wire logic signed [word_ctrl_pkg::PER_W-1:0] step_sx =
        word_ctrl_pkg::PER_W'(signed'(step_r));

    always_comb begin
        period_nxt = period_r;
        step_nxt = step_r;
        result_nxt = result_r;
        rx_word_nxt = rx_word_r;
        shin_nxt = shin_r;
        shout_nxt = shout_r;
        bitcnt_nxt = bitcnt_r;
        active_nxt = active_r;
        armed_nxt = armed_r;
        last_act_nxt = last_act_r;
        cnt_nxt = cnt_r + 16'h0001;
        limit_nxt = limit_r;
        half_cnt_nxt = (half_cnt_r == 16'hffff) ? half_cnt_r : half_cnt_r + 16'h0001;
        half_run_nxt = half_run_r;
        strobe_nxt = 1'b0;
        fs2_nxt = 1'b1;
        dout_nxt = dout_r;
        prdata_nxt = 32'h0000_0000;
        pready_nxt = apb_acc;
        pslverr_nxt = 1'b0;
        // apb register access
        if (apb_wr) begin
            case (paddr)
                word_ctrl_pkg::CTRL_OFS: step_nxt = pwdata[word_ctrl_pkg::STEP_W-1:0];
                word_ctrl_pkg::STEP_OFS: step_nxt = pwdata[word_ctrl_pkg::STEP_W-1:0];
                word_ctrl_pkg::PERIOD_OFS: period_nxt = pwdata[word_ctrl_pkg::PER_W-1:0];
                word_ctrl_pkg::RESULT_OFS: result_nxt = pwdata[word_ctrl_pkg::WORD_W-1:0];
                default: pslverr_nxt = 1'b1;
            endcase
        end else if (apb_acc) begin
            case (paddr)
                word_ctrl_pkg::CTRL_OFS: prdata_nxt = {24'h00_0000, step_r};
                word_ctrl_pkg::STEP_OFS: prdata_nxt = {24'h00_0000, step_r};
                word_ctrl_pkg::PERIOD_OFS: prdata_nxt = {16'h0000, period_r};
                word_ctrl_pkg::DATA_OFS: prdata_nxt = {16'h0000, rx_word_r};
                word_ctrl_pkg::RESULT_OFS: prdata_nxt = {16'h0000, result_r};
                word_ctrl_pkg::STATUS_OFS: prdata_nxt = {29'h0000_0000, active_r, last_act_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
        // (RL1) frame start on falling frame sync
        if (fs_low && !armed_r && !active_r) begin
            active_nxt = 1'b1;
            armed_nxt = 1'b1;
            bitcnt_nxt = word_ctrl_pkg::BITCNT_TOP;
            half_cnt_nxt = 16'h0000;
            shout_nxt = result_r;
            dout_nxt = result_r[15];
        end
        if (!fs_low && !active_r) begin
            armed_nxt = 1'b0;
        end
        // (RL9) output on rising shift edge
        if (active_r && sck_rise && bitcnt_r != word_ctrl_pkg::BITCNT_TOP) begin
            dout_nxt = shout_r[15];
        end
        // (RL9) input on falling shift edge
        if (active_r && sck_fall) begin
            shin_nxt = {shin_r[14:0], din_s};
            shout_nxt = {shout_r[14:0], 1'b0};
            bitcnt_nxt = bitcnt_r - 4'h1;
            if (bitcnt_r == word_ctrl_pkg::BITCNT_LAST) begin
                active_nxt = 1'b0;
                rx_word_nxt = {shin_r[14:0], din_s};
                last_act_nxt = decode({shin_r[0], din_s}, pins_s);
                // (RL10) signed step, one period only
                case (decode({shin_r[0], din_s}, pins_s))
                    // (RL2) (RL5) later sampling
                    word_ctrl_pkg::ACT_LATER: limit_nxt = period_r + step_sx;
                    // (RL3) (RL6) earlier sampling
                    word_ctrl_pkg::ACT_EARLIER: limit_nxt = period_r - step_sx;
                    // (RL4) (RL7) secondary frame at half period
                    word_ctrl_pkg::ACT_SECOND: half_run_nxt = 1'b1;
                    default: limit_nxt = limit_r;
                endcase
            end
        end
        // sampling timer; a pending step replaces one period
        if (cnt_r + 16'h0001 >= limit_r) begin
            cnt_nxt = 16'h0000;
            strobe_nxt = 1'b1;
            limit_nxt = period_r;
        end
        if (half_run_r && half_cnt_r >= {1'b0, period_r[15:1]}) begin
            fs2_nxt = 1'b0;
            half_run_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_r <= word_ctrl_pkg::PERIOD_RST;
            step_r <= word_ctrl_pkg::STEP_RST;
            result_r <= 16'h0000;
            rx_word_r <= 16'h0000;
            shin_r <= 16'h0000;
            shout_r <= 16'h0000;
            bitcnt_r <= 4'h0;
            active_r <= 1'b0;
            armed_r <= 1'b0;
            last_act_r <= 2'b00;
            cnt_r <= 16'h0000;
            limit_r <= word_ctrl_pkg::PERIOD_RST;
            half_cnt_r <= 16'h0000;
            half_run_r <= 1'b0;
            strobe_r <= 1'b0;
            fs2_r <= 1'b1;
            dout_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            period_r <= period_nxt;
            step_r <= step_nxt;
            result_r <= result_nxt;
            rx_word_r <= rx_word_nxt;
            shin_r <= shin_nxt;
            shout_r <= shout_nxt;
            bitcnt_r <= bitcnt_nxt;
            active_r <= active_nxt;
            armed_r <= armed_nxt;
            last_act_r <= last_act_nxt;
            cnt_r <= cnt_nxt;
            limit_r <= limit_nxt;
            half_cnt_r <= half_cnt_nxt;
            half_run_r <= half_run_nxt;
            strobe_r <= strobe_nxt;
            fs2_r <= fs2_nxt;
            dout_r <= dout_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign data_out = dout_r;
    assign second_frame_sync_n = fs2_r;
    assign sample_strobe = strobe_r;

    // (RL8) ignored codes start no secondary frame
    property p_no_second;
        @(posedge pclk) disable iff (!presetn)
        (last_act_r != 2'b11 && !half_run_r) |-> second_frame_sync_n;
    endproperty
    a_no_second: assert property (p_no_second) else $error("stray secondary frame"); // (RL8)
    // (RL4) secondary frame follows its request
    property p_second;
        @(posedge pclk) disable iff (!presetn)
        $fell(half_run_r) |-> !second_frame_sync_n;
    endproperty
    a_second: assert property (p_second) else $error("secondary frame missing"); // (RL4)
    // (RL7) secondary frame is one cycle
    property p_second_pulse;
        @(posedge pclk) disable iff (!presetn)
        !second_frame_sync_n |=> second_frame_sync_n;
    endproperty
    a_second_pulse: assert property (p_second_pulse) else $error("secondary frame too long"); // (RL7)
    // (RL10) strobe restarts the timer
    property p_strobe_restart;
        @(posedge pclk) disable iff (!presetn)
        sample_strobe |-> (cnt_r == 16'h0000 && limit_r == $past(period_r));
    endproperty
    a_strobe_restart: assert property (p_strobe_restart) else $error("period not resumed"); // (RL10)
    // (RL1) sixteen falling shift edges per frame
    property p_frame_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(active_r) |-> bitcnt_r == 4'hf;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not sixteen bits"); // (RL1)
    // (RL9) output only moves on rising shift edge or frame start
    property p_dout_edge;
        @(posedge pclk) disable iff (!presetn)
        $changed(data_out) |-> ($past(sck_rise) || $rose(active_r));
    endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("output moved off edge"); // (RL9)
    // (RL2) later step adds the signed step to the period
    property p_later;
        @(posedge pclk) disable iff (!presetn)
        ($changed(last_act_r) && last_act_r == 2'b01 && !$past(sample_strobe, 1))
            |-> limit_r == period_r + step_sx || sample_strobe;
    endproperty
    a_later: assert property (p_later) else $error("later step wrong"); // (RL2)
    // (RL3) earlier step subtracts the signed step from the period
    property p_earlier;
        @(posedge pclk) disable iff (!presetn)
        ($changed(last_act_r) && last_act_r == 2'b10 && !$past(sample_strobe, 1))
            |-> limit_r == period_r - step_sx || sample_strobe;
    endproperty
    a_earlier: assert property (p_earlier) else $error("earlier step wrong"); // (RL3)
endmodule : primary_word_control_decode
`default_nettype wire

//--- common/word_ctrl_pkg.sv
// constants for the primary word control decode block
`default_nettype none
package word_ctrl_pkg;
    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STEP_OFS = 8'h04;
    localparam logic [7:0] PERIOD_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0c;
    localparam logic [7:0] RESULT_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    // field widths and reset values
    localparam int WORD_W = 16;
    localparam int STEP_W = 8;
    localparam int PER_W = 16;
    localparam logic [PER_W-1:0] PERIOD_RST = 16'h0100;
    localparam logic [STEP_W-1:0] STEP_RST = 8'h00;
    localparam logic [3:0] BITCNT_LAST = 4'h0;
    localparam logic [3:0] BITCNT_TOP = 4'hf;
    // decoded action of one primary word
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_LATER = 2'b01,
        ACT_EARLIER = 2'b10,
        ACT_SECOND = 2'b11
    } action_e;
endpackage : word_ctrl_pkg
`default_nettype wire

//--- testbench/host_serial_model.sv
// serial host model that drives primary frames and captures the result
`default_nettype none
module host_serial_model (
    // clock
    input wire logic pclk,
    // link toward the device
    output logic shift_clk,
    output logic frame_sync_n,
    output logic data_in,
    input wire logic data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // shift clock stands still low between frames
    initial begin
        shift_clk = 1'b0;
        frame_sync_n = 1'b1;
        data_in = 1'b0;
    end
    // each shift half period is 16 pclk, 160 ns in all
    task automatic frame(input logic [15:0] w, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--) begin
            @(posedge pclk);
            // host data moves on the rise
            shift_clk <= 1'b1;
            data_in <= w[i];
            // frame opens at the falling sync edge
            if (i == 15) frame_sync_n <= 1'b0;
            repeat (16) @(posedge pclk);
            // device data taken on the fall
            shift_clk <= 1'b0;
            rx[i] = data_out;
            if (i == 14) frame_sync_n <= 1'b1;
            repeat (15) @(posedge pclk);
        end
        // released line must not keep looking valid
        data_in <= ~w[0];
    endtask : frame
endmodule : host_serial_model
`default_nettype wire

//--- testbench/primary_word_control_decode_tb.sv
// self-checking bench for the primary word control decode block
`default_nettype none
module primary_word_control_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PER = 16'h0600;
    localparam logic [15:0] RES = 16'ha5c3;
    // ctrl, high pin, low pin, step, expected action
    localparam logic [13:0] CASES [9] = '{14'h0040, 14'h0441, 14'h0842, 14'h0c43,
        14'h13c1, 14'h23c2, 14'h3043, 14'h1440, 14'h2840};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, errv, shift_clk, frame_sync_n, data_in, data_out;
    logic second_frame_sync_n, sample_strobe;
    logic function_pin_low = 1'b0;
    logic function_pin_high = 1'b0;
    int failures = 0, check_count = 0, cyc = 0, last_strobe = 0, gap = 0, strobes = 0;
    logic fs_q = 1'b1;
    int fs_fall = 0, sec_at = 0, secs = 0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        fs_q <= frame_sync_n;
        if (fs_q === 1'b1 && frame_sync_n === 1'b0) fs_fall <= cyc;
        if (second_frame_sync_n === 1'b0) begin
            sec_at <= cyc;
            secs <= secs + 1;
        end
        if (sample_strobe === 1'b1) begin
            last_strobe <= cyc;
            gap <= cyc - last_strobe;
            strobes <= strobes + 1;
        end
    end
    primary_word_control_decode u_primary_word_control_decode (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .shift_clk(shift_clk),
        .frame_sync_n(frame_sync_n), .data_in(data_in), .function_pin_low(function_pin_low),
        .function_pin_high(function_pin_high), .data_out(data_out),
        .second_frame_sync_n(second_frame_sync_n), .sample_strobe(sample_strobe));
    host_serial_model u_host_serial_model (.pclk(pclk), .shift_clk(shift_clk),
        .frame_sync_n(frame_sync_n), .data_in(data_in), .data_out(data_out));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check
    // request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_regs();
        apb(1'b0, word_ctrl_pkg::PERIOD_OFS, 32'h0000_0000);
        check(rdv[15:0], word_ctrl_pkg::PERIOD_RST, "period reset");
        apb(1'b0, 8'h18, 32'h0000_0000);
        check(errv, 1'b1, "unmapped refused");
        apb(1'b1, word_ctrl_pkg::PERIOD_OFS, {16'h0000, PER});
        apb(1'b1, word_ctrl_pkg::RESULT_OFS, {16'h0000, RES});
        repeat (3000) @(posedge pclk);
    endtask : t_regs
    task automatic t_frame(input logic [13:0] v);
        logic [15:0] w, rx;
        int prev, k0, k1, n, d;
        w = {14'h2d3b ^ {12'h000, v[13:12]}, v[13:12]};
        d = (v[1:0] == 2'h1) ? $signed(v[9:2]) : (v[1:0] == 2'h2) ? -$signed(v[9:2]) : 0;
        apb(1'b1, word_ctrl_pkg::STEP_OFS, {24'h00_0000, v[9:2]});
        function_pin_high <= v[11];
        function_pin_low <= v[10];
        // start just after a strobe so a step never meets the timer wrap
        @(posedge pclk iff sample_strobe === 1'b1);
        @(posedge pclk);
        prev = last_strobe;
        k0 = strobes;
        k1 = secs;
        u_host_serial_model.frame(w, rx);
        check(rx, RES, "result word");
        n = 0;
        while (strobes < k0 + 4 && n < 6 * PER) begin
            @(posedge pclk);
            n++;
        end
        check(last_strobe - prev, 4 * PER + d, "period shift");
        check(gap, PER, "period resumed");
        check(secs - k1, v[1:0] == 2'h3, "second sync count");
        check(secs == k1 || (sec_at - fs_fall >= PER / 2 && sec_at - fs_fall < PER / 2 + 16),
            1'b1, "second sync time");
        apb(1'b0, word_ctrl_pkg::STATUS_OFS, 32'h0000_0000);
        check(rdv[1:0], v[1:0], "decoded action");
        apb(1'b0, word_ctrl_pkg::DATA_OFS, 32'h0000_0000);
        check(rdv[15:2], w[15:2], "received word");
    endtask : t_frame
    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        for (int k = 0; k < 9; k++) t_frame(CASES[k]);
        end_of_test();
    end
    initial begin
        #480000;
        failures++;
        end_of_test();
    end
endmodule : primary_word_control_decode_tb
`default_nettype wire
